// ==== core/can_transceiver_control.sv ====
// Digital control of a high-speed CAN transceiver with wake and diagnostics.
`timescale 1ns/100ps
module can_transceiver_control #(
    parameter int TXD_DOM_CYCLES  = can_xcvr_pkg::TXD_DOM_CYC,
    parameter int WAKE_WIN_CYCLES = can_xcvr_pkg::WAKE_WINDOW_CYC,
    parameter int FIFO_DEPTH      = can_xcvr_pkg::FIFO_DEPTH
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_cfg_write,
    input  wire logic [1:0]            i_cfg_mode,
    input  wire logic [1:0]            i_cfg_slew,
    input  wire logic                  i_cfg_wake_en,
    input  wire logic                  i_cfg_single_pulse,
    input  wire logic                  i_chip_normal,
    input  wire logic                  i_txd,
    input  wire logic                  i_bus_dominant,
    input  wire logic                  i_wake_rx_dominant,
    input  wire can_xcvr_pkg::cmp_type i_cmp,
    input  wire logic                  i_wake_flag_clear,
    input  wire logic                  i_txd_flag_clear,
    input  wire logic                  i_fault_ready,
    output logic                       o_rxd,
    output logic                       o_drv_en,
    output logic                       o_drv_dominant,
    output logic                       o_rx_en,
    output logic                       o_bias_gnd,
    output logic                       o_split_en,
    output logic [1:0]                 o_slew,
    output logic                       o_wake_rx_en,
    output logic                       o_wake_flag,
    output logic                       o_wake_irq,
    output logic                       o_wake_chip,
    output logic                       o_txd_dom_flag,
    output can_xcvr_pkg::fault_type    o_fault,
    output logic                       o_fault_valid,
    output logic                       o_fault_overrun
);
    initial begin
        if (TXD_DOM_CYCLES < 2 || WAKE_WIN_CYCLES < 2 || FIFO_DEPTH < 2) begin
            $error("can_transceiver_control: counts too small");
        end
    end

    localparam int TW = $clog2(TXD_DOM_CYCLES + 1);
    localparam int WW = $clog2(WAKE_WIN_CYCLES + 1);
    localparam int PW = $clog2(can_xcvr_pkg::WAKE_SINGLE_CYC + 1);
    localparam int FW = $clog2(can_xcvr_pkg::FAULT_CYCLES + 1);

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    can_xcvr_pkg::mode_type mode;
    logic [1:0]             slew;
    logic                   wake_en;
    logic                   single_pulse;

    wire logic [1:0] slew_ok = (i_cfg_slew > can_xcvr_pkg::SLEW_MAX)
                               ? can_xcvr_pkg::SLEW_MAX : i_cfg_slew;
    wire can_xcvr_pkg::mode_type mode_ok =
        (i_cfg_mode == 2'h3) ? can_xcvr_pkg::MODE_RESET
                             : can_xcvr_pkg::mode_type'(i_cfg_mode);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode         <= can_xcvr_pkg::MODE_RESET;
            slew         <= can_xcvr_pkg::SLEW_RESET;
            wake_en      <= 1'b0;
            single_pulse <= 1'b0;
        end else if (i_cfg_write) begin
            mode         <= mode_ok;
            slew         <= slew_ok;
            wake_en      <= i_cfg_wake_en;
            single_pulse <= i_cfg_single_pulse;
        end
    end

    // ------------------------------------------------------------
    // Driver and receiver path
    // ------------------------------------------------------------
    logic          drv_armed;
    logic [TW-1:0] txd_cnt;
    logic          txd_dom;

    wire is_txrx  = (mode == can_xcvr_pkg::MODE_TXRX);
    wire is_sleep = (mode == can_xcvr_pkg::MODE_SLEEP) || !i_chip_normal;
    wire arm_ok   = is_txrx && i_chip_normal && !txd_dom;
    wire next_arm = arm_ok && (drv_armed || i_txd);
    wire txd_hit  = !i_txd && (txd_cnt == TW'(TXD_DOM_CYCLES - 1));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            drv_armed <= 1'b0;
        end else begin
            drv_armed <= next_arm;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || i_txd || !drv_armed) begin
            txd_cnt <= '0;
        end else if (txd_cnt != TW'(TXD_DOM_CYCLES)) begin
            txd_cnt <= txd_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            txd_dom <= 1'b0;
        end else if (drv_armed && txd_hit) begin
            txd_dom <= 1'b1;
        end else if (i_txd_flag_clear && i_txd) begin
            txd_dom <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_drv_en       <= 1'b0;
            o_drv_dominant <= 1'b0;
            o_rx_en        <= 1'b0;
            o_rxd          <= 1'b1;
            o_bias_gnd     <= 1'b1;
            o_split_en     <= 1'b0;
            o_slew         <= can_xcvr_pkg::SLEW_RESET;
            o_txd_dom_flag <= 1'b0;
        end else begin
            o_drv_en       <= next_arm;
            o_drv_dominant <= next_arm && !i_txd;
            o_rx_en        <= !is_sleep;
            o_rxd          <= is_sleep || !i_bus_dominant;
            o_bias_gnd     <= is_sleep;
            o_split_en     <= !is_sleep;
            o_slew         <= slew;
            o_txd_dom_flag <= txd_dom || (drv_armed && txd_hit);
        end
    end

    // ------------------------------------------------------------
    // Wake detector
    // ------------------------------------------------------------
    logic [PW-1:0] pulse_cnt;
    logic [WW-1:0] win_cnt;
    logic [1:0]    pulses;
    logic          wake_rx_prev;

    wire wake_armed = is_sleep && wake_en;
    wire pulse_end  = wake_rx_prev && !i_wake_rx_dominant;
    wire pulse_ok   = pulse_cnt >= PW'(can_xcvr_pkg::WAKE_PULSE_CYC);
    wire single_hit = single_pulse && i_wake_rx_dominant &&
                      (pulse_cnt == PW'(can_xcvr_pkg::WAKE_SINGLE_CYC - 1));
    wire win_open   = (pulses != 2'd0);
    wire win_expire = win_open && (win_cnt == WW'(WAKE_WIN_CYCLES - 1));
    wire pattern_hit = !single_pulse && pulse_end && pulse_ok &&
                       (pulses == 2'(can_xcvr_pkg::WAKE_PULSES - 1)) &&
                       !win_expire;
    wire wake_hit   = wake_armed && (single_hit || pattern_hit);

    always_ff @(posedge i_clk) begin
        if (i_rst || !wake_armed || !i_wake_rx_dominant) begin
            pulse_cnt <= '0;
        end else if (pulse_cnt != PW'(can_xcvr_pkg::WAKE_SINGLE_CYC)) begin
            pulse_cnt <= pulse_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !wake_armed || wake_hit || win_expire) begin
            pulses  <= 2'd0;
            win_cnt <= '0;
        end else begin
            if (pulse_end && pulse_ok && !single_pulse) begin
                pulses <= pulses + 2'd1;
            end
            if (win_open || (pulse_end && pulse_ok && !single_pulse)) begin
                win_cnt <= win_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wake_rx_prev <= 1'b0;
            o_wake_flag  <= 1'b0;
            o_wake_irq   <= 1'b0;
            o_wake_chip  <= 1'b0;
            o_wake_rx_en <= 1'b0;
        end else begin
            wake_rx_prev <= i_wake_rx_dominant && wake_armed;
            o_wake_flag  <= wake_hit || (o_wake_flag && !i_wake_flag_clear);
            o_wake_irq   <= wake_hit;
            o_wake_chip  <= wake_hit && !i_chip_normal;
            o_wake_rx_en <= wake_armed;
        end
    end

    // ------------------------------------------------------------
    // Bus fault decode
    // ------------------------------------------------------------
    can_xcvr_pkg::fault_type rec_f;
    can_xcvr_pkg::fault_type seen;
    can_xcvr_pkg::fault_type reported;
    logic [FW-1:0]           match_cnt;
    logic                    dom_prev;
    logic                    fifo_ready;

    wire cmp_gnd_ok_r = i_cmp.gnd_low && i_cmp.gnd_high;
    wire dom_now      = o_drv_dominant;
    can_xcvr_pkg::fault_type dom_f;
    always_comb begin
        dom_f.low_gnd   = rec_f.low_gnd  && !i_cmp.gnd_low &&  i_cmp.gnd_high;
        dom_f.high_gnd  = rec_f.high_gnd && !i_cmp.gnd_low && !i_cmp.gnd_high;
        dom_f.low_bat   = rec_f.low_bat  &&  i_cmp.bat_low &&  i_cmp.bat_high;
        dom_f.high_bat  = rec_f.high_bat && !i_cmp.bat_low &&  i_cmp.bat_high;
        dom_f.low_rail  = rec_f.low_rail &&  i_cmp.rail_low && i_cmp.rail_high;
        dom_f.high_rail = rec_f.high_rail && !i_cmp.rail_low &&
                          i_cmp.rail_high;
    end

    // A finished cycle is matched against the word of the cycle before it.
    wire cycle_done = dom_prev && !dom_now;
    wire same_fault = (seen == reported) && (seen != '0);
    wire new_fault  = (seen != '0);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rec_f <= '0;
        end else if (!dom_now && o_drv_en) begin
            rec_f.low_gnd   <= !cmp_gnd_ok_r && !i_cmp.gnd_low;
            rec_f.high_gnd  <= !cmp_gnd_ok_r && !i_cmp.gnd_high;
            rec_f.low_bat   <= i_cmp.bat_low && i_cmp.bat_high;
            rec_f.high_bat  <= i_cmp.bat_low && i_cmp.bat_high;
            rec_f.low_rail  <= i_cmp.rail_low && i_cmp.rail_high;
            rec_f.high_rail <= i_cmp.rail_low && i_cmp.rail_high;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dom_prev  <= 1'b0;
            seen      <= '0;
            match_cnt <= '0;
            reported  <= '0;
        end else begin
            dom_prev <= dom_now;
            if (dom_now) begin
                seen <= dom_f;
            end
            if (cycle_done) begin
                reported <= seen;
                if (same_fault && match_cnt != FW'(can_xcvr_pkg::FAULT_CYCLES))
                begin
                    match_cnt <= match_cnt + 1'b1;
                end else if (!same_fault) begin
                    match_cnt <= FW'(new_fault);
                end
            end
        end
    end

    wire fault_push = cycle_done && same_fault &&
                      (match_cnt == FW'(can_xcvr_pkg::FAULT_CYCLES - 1));
    can_xcvr_pkg::fault_type fifo_data;
    logic                    fifo_valid;

    fault_fifo #(
        .WIDTH (can_xcvr_pkg::FAULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_data  (seen),
        .i_valid (fault_push),
        .o_ready (fifo_ready),
        .o_data  (fifo_data),
        .o_valid (fifo_valid),
        .i_ready (i_fault_ready && !o_fault_valid)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_fault         <= '0;
            o_fault_valid   <= 1'b0;
            o_fault_overrun <= 1'b0;
        end else begin
            if (fifo_valid && i_fault_ready && !o_fault_valid) begin
                o_fault       <= fifo_data;
                o_fault_valid <= 1'b1;
            end else begin
                o_fault_valid <= 1'b0;
            end
            o_fault_overrun <= o_fault_overrun ||
                               (fault_push && !fifo_ready);
        end
    end
endmodule : can_transceiver_control

// ==== core/can_xcvr_pkg.sv ====
// Shared constants and types for the CAN transceiver control block.
package can_xcvr_pkg;

    // ------------------------------------------------------------
    // Timing, counts and sizes
    // ------------------------------------------------------------
    localparam int CLK_NS              = 10;
    localparam int TXD_DOM_MIN_US      = 300;
    localparam int TXD_DOM_CYC         = (TXD_DOM_MIN_US * 1000 + CLK_NS - 1)
                                         / CLK_NS;
    localparam int WAKE_PULSE_MIN_NS   = 500;
    localparam int WAKE_PULSE_CYC      = (WAKE_PULSE_MIN_NS + CLK_NS - 1)
                                         / CLK_NS;
    localparam int WAKE_SINGLE_NS      = 2000;
    localparam int WAKE_SINGLE_CYC     = (WAKE_SINGLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_WINDOW_US      = 120;
    localparam int WAKE_WINDOW_CYC     = (WAKE_WINDOW_US * 1000) / CLK_NS;
    localparam int WAKE_PULSES         = 3;
    localparam int FAULT_CYCLES        = 5;
    localparam int FIFO_DEPTH          = 8;

    // ------------------------------------------------------------
    // Reset values, limits and mode encoding
    // ------------------------------------------------------------
    localparam logic [1:0] SLEW_RESET  = 2'h0;
    localparam logic [1:0] SLEW_MAX    = 2'h2;

    typedef enum logic [1:0] {
        MODE_SLEEP   = 2'b00,
        MODE_RX_ONLY = 2'b01,
        MODE_TXRX    = 2'b10
    } mode_type;

    localparam mode_type MODE_RESET    = MODE_SLEEP;

    // Three comparator pairs (gnd, bat, rail): in each pair the upper bit is the low line, the lower bit the high line.
    typedef struct packed {
        logic gnd_low;
        logic gnd_high;
        logic bat_low;
        logic bat_high;
        logic rail_low;
        logic rail_high;
    } cmp_type;

    // Decoded fault word, also the FIFO payload.
    typedef struct packed {
        logic low_gnd;
        logic high_gnd;
        logic low_bat;
        logic high_bat;
        logic low_rail;
        logic high_rail;
    } fault_type;

    localparam int FAULT_W             = $bits(fault_type);

endpackage : can_xcvr_pkg

// ==== core/fault_fifo.sv ====
// Small synchronous FIFO for reported bus fault words.
`timescale 1ns/100ps
module fault_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("fault_fifo: depth must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                              (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              empty = (wr_ptr == rd_ptr);
    wire              push  = i_valid && !full;
    wire              pop   = !empty && i_ready;

    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule : fault_fifo

// ==== testbench/can_mcu_model.sv ====
// Behavioural CAN protocol controller that drives the transmit input.
`timescale 1ns/100ps
module can_mcu_model (
    input  wire logic i_clk,
    input  wire logic i_rxd,
    output logic      o_txd
);
    logic last_rxd;

    initial o_txd = 1'b1;

    always @(posedge i_clk) last_rxd <= i_rxd;

    // Holds one transmit level for a number of clock cycles.
    task automatic drive(input logic level, input int cycles);
        o_txd <= level;
        repeat (cycles) @(posedge i_clk);
    endtask : drive

    // Random frame body; a dominant run never exceeds five bits.
    task automatic frame(input int bits, input int bit_cyc);
        int   run;
        logic b;
        run = 0;
        for (int i = 0; i < bits; i++) begin
            b = 1'($urandom_range(1, 0));
            if (run == 5) b = 1'b1;
            run = b ? 0 : run + 1;
            drive(b, bit_cyc);
        end
        drive(1'b1, bit_cyc);
    endtask : frame
endmodule : can_mcu_model

// ==== testbench/can_transceiver_control_asserts.sv ====
// Port-level assertions for the CAN transceiver control block.
`timescale 1ns/100ps
module can_xcvr_checker #(
    parameter int TXD_DOM_CYCLES = 20
) (
    input wire logic                    i_clk,
    input wire logic                    i_rst,
    input wire logic                    i_cfg_write,
    input wire logic [1:0]              i_cfg_slew,
    input wire logic                    i_chip_normal,
    input wire logic                    i_txd,
    input wire logic                    i_bus_dominant,
    input wire logic                    o_rxd,
    input wire logic                    o_drv_en,
    input wire logic                    o_drv_dominant,
    input wire logic                    o_rx_en,
    input wire logic                    o_bias_gnd,
    input wire logic                    o_split_en,
    input wire logic [1:0]              o_slew,
    input wire logic                    o_wake_flag,
    input wire logic                    o_wake_irq,
    input wire logic                    o_txd_dom_flag,
    input wire can_xcvr_pkg::fault_type o_fault,
    input wire logic                    o_fault_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    int low_cnt;

    // Counts edges with the transmit input held low.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_txd) low_cnt <= 0;
        else if (low_cnt < TXD_DOM_CYCLES) low_cnt <= low_cnt + 1;
    end

    sequence s_wake_pulse;
        o_wake_irq ##1 !o_wake_irq;
    endsequence
    sequence s_quiet8;
        !o_txd_dom_flag [*8];
    endsequence

    AST_RXD: assert property (
        (o_rx_en && i_chip_normal && !i_cfg_write && !$past(i_cfg_write))
        |=> (o_rxd == !$past(i_bus_dominant))) else $error("rxd wrong");
    AST_TXD_REC: assert property (
        (o_drv_en && i_txd) |=> !o_drv_dominant) else $error("not recessive");
    AST_SLEEP: assert property (
        o_bias_gnd |-> !(o_drv_en || o_split_en || o_rx_en))
        else $error("sleep outputs");
    AST_NOT_NORMAL: assert property (
        !i_chip_normal |=> !o_drv_en) else $error("driver outside normal");
    AST_ARM: assert property (
        $rose(o_drv_en) |-> ($past(i_txd) && $past(i_chip_normal)))
        else $error("driver armed badly");
    AST_SLEW: assert property (
        i_cfg_write |=> ##1 (o_slew == (($past(i_cfg_slew, 2) >
        can_xcvr_pkg::SLEW_MAX) ? can_xcvr_pkg::SLEW_MAX
        : $past(i_cfg_slew, 2)))) else $error("slew");
    AST_IRQ: assert property (
        o_wake_irq |-> s_wake_pulse) else $error("wake pulse width");
    AST_IRQ_FLAG: assert property (
        o_wake_irq |-> ##[0:1] o_wake_flag) else $error("wake flag missing");
    AST_QUIET: assert property (
        (!o_txd_dom_flag && $fell(i_txd)) |=> s_quiet8)
        else $error("dominant flag early");
    AST_CNT: assert property (
        $rose(o_txd_dom_flag) |-> (low_cnt >= TXD_DOM_CYCLES - 1))
        else $error("dominant flag before timeout");
    AST_RELEASE: assert property (
        $rose(o_txd_dom_flag) |-> ##[0:1] !o_drv_en)
        else $error("driver not released");
    AST_FAULT: assert property (
        o_fault_valid |-> (o_fault != '0)) else $error("empty fault");
endmodule : can_xcvr_checker

bind can_transceiver_control can_xcvr_checker #(
    .TXD_DOM_CYCLES(TXD_DOM_CYCLES)
) chk (.*);

// ==== testbench/tb_can_transceiver_control.sv ====
// Self-checking bench for the CAN transceiver control block.
`timescale 1ns/100ps
module tb_can_transceiver_control;
    localparam int TDOM = 20;
    localparam int WWIN = 400;
    localparam logic [5:0] REC [6] = '{6'h00, 6'h00, 6'h3C, 6'h3C, 6'h33,
                                       6'h33};
    localparam logic [5:0] DOM [6] = '{6'h10, 6'h00, 6'h1C, 6'h14, 6'h13,
                                       6'h11};
    logic       i_clk, i_rst, cfg_write, wake_en, single, chip_normal;
    logic       bus_dom, wake_dom, wflag_clr, tflag_clr, fault_ready, txd;
    logic       rxd, drv_en, drv_dom, rx_en, bias_gnd, split_en, wake_rx_en;
    logic       wake_flag, wake_irq, wake_chip, txd_flag, fault_valid;
    logic       watch, loop, t_s, b_s, overrun;
    logic [1:0] cfg_mode, cfg_slew, slew;
    can_xcvr_pkg::cmp_type   cmp;
    can_xcvr_pkg::fault_type fault, last_fault;
    int         miscompares, num_checks, irq_cnt, chip_cnt, fault_cnt, r;

    can_transceiver_control #(.TXD_DOM_CYCLES(TDOM), .WAKE_WIN_CYCLES(WWIN),
        .FIFO_DEPTH(can_xcvr_pkg::FIFO_DEPTH)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_cfg_write(cfg_write),
        .i_cfg_mode(cfg_mode), .i_cfg_slew(cfg_slew), .i_cfg_wake_en(wake_en),
        .i_cfg_single_pulse(single), .i_chip_normal(chip_normal),
        .i_txd(txd), .i_bus_dominant(bus_dom), .i_wake_rx_dominant(wake_dom),
        .i_cmp(cmp), .i_wake_flag_clear(wflag_clr),
        .i_txd_flag_clear(tflag_clr), .i_fault_ready(fault_ready),
        .o_rxd(rxd), .o_drv_en(drv_en), .o_drv_dominant(drv_dom),
        .o_rx_en(rx_en), .o_bias_gnd(bias_gnd), .o_split_en(split_en),
        .o_slew(slew), .o_wake_rx_en(wake_rx_en), .o_wake_flag(wake_flag),
        .o_wake_irq(wake_irq), .o_wake_chip(wake_chip),
        .o_txd_dom_flag(txd_flag), .o_fault(fault),
        .o_fault_valid(fault_valid), .o_fault_overrun(overrun));

    can_mcu_model mcu (.i_clk(i_clk), .i_rxd(rxd), .o_txd(txd));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // Tasks and functions
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
    endtask : step

    task automatic cfg(input logic [1:0] m, input logic [1:0] s,
                       input logic we, input logic sp);
        cfg_write <= 1'b1;
        cfg_mode <= m;
        cfg_slew <= s;
        wake_en <= we;
        single <= sp;
        step(1);
        cfg_write <= 1'b0;
        step(2);
    endtask : cfg

    task automatic pulse(input int len);
        wake_dom <= 1'b1;
        step(len);
        wake_dom <= 1'b0;
        step(10);
    endtask : pulse

    task automatic clear_wake;
        wflag_clr <= 1'b1;
        step(1);
        wflag_clr <= 1'b0;
        step(2);
    endtask : clear_wake

    // Comparators follow the driven bus, one cycle behind the transmit pin.
    task automatic run_fault(input int k, input int n);
        cmp <= REC[k];
        mcu.drive(1'b1, 2);
        for (int i = 0; i < n; i++) begin
            mcu.drive(1'b0, 1);
            cmp <= DOM[k];
            mcu.drive(1'b0, 3);
            mcu.drive(1'b1, 1);
            cmp <= REC[k];
            mcu.drive(1'b1, 3);
        end
    endtask : run_fault

    function automatic logic [1:0] exp_slew(input logic [1:0] v);
        return (v > can_xcvr_pkg::SLEW_MAX) ? can_xcvr_pkg::SLEW_MAX : v;
    endfunction : exp_slew

    always @(posedge i_clk) begin
        t_s = txd;
        b_s = bus_dom;
        if (wake_irq) irq_cnt++;
        if (wake_chip) chip_cnt++;
        if (fault_valid) fault_cnt++;
        if (fault_valid) last_fault = fault;
        if (loop) bus_dom <= drv_dom;
        #1;
        if (watch) check({drv_dom, rxd}, {~t_s, ~b_s}, "echo");
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        give_verdict;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {cfg_write, wake_en, single, chip_normal, bus_dom} = '0;
        {wake_dom, wflag_clr, tflag_clr, watch, loop} = '0;
        {cfg_mode, cfg_slew, miscompares, num_checks} = '0;
        {irq_cnt, chip_cnt, fault_cnt} = '0;
        i_rst = 1'b1;
        fault_ready = 1'b1;
        cmp = 6'h30;
        void'($urandom(9));
        step(6);
        i_rst <= 1'b0;
        step(2);
        check(slew, 8'h00, "slew default");
        check({bias_gnd, split_en, drv_en, rxd}, 8'h09, "reset");
        for (int s = 0; s < 4; s++) begin
            cfg(2'h0, 2'(s), 1'b0, 1'b0);
            check(slew, exp_slew(2'(s)), "slew");
        end
        chip_normal <= 1'b1;
        cfg(2'h1, 2'h0, 1'b0, 1'b0);
        repeat (20) begin
            r = $urandom_range(3, 0);
            bus_dom <= r[0];
            mcu.drive(r[1], 1);
            step(1);
            check({rxd, drv_en, drv_dom}, {~r[0], 2'h0}, "rx only");
        end
        mcu.drive(1'b0, 1);
        cfg(2'h2, 2'h1, 1'b0, 1'b0);
        check(drv_en, 8'h00, "arm low");
        mcu.drive(1'b1, 1);
        step(1);
        check(drv_en, 8'h01, "arm high");
        loop = 1'b1;
        watch = 1'b1;
        mcu.frame(40, 2);
        watch = 1'b0;
        loop = 1'b0;
        chip_normal <= 1'b0;
        step(2);
        check(drv_en, 8'h00, "not normal");
        chip_normal <= 1'b1;
        step(2);
        check({drv_en, bias_gnd, split_en}, 8'h05, "renormal");
        mcu.drive(1'b0, TDOM - 5);
        check(txd_flag, 8'h00, "dom early");
        mcu.drive(1'b0, 15);
        check({txd_flag, drv_en}, 8'h02, "dom flag");
        mcu.drive(1'b1, 2);
        tflag_clr <= 1'b1;
        step(1);
        tflag_clr <= 1'b0;
        cfg(2'h2, 2'h0, 1'b0, 1'b0);
        check({txd_flag, drv_en}, 8'h01, "rearm");
        for (int k = 0; k < 6; k++) begin
            fault_cnt = 0;
            cmp <= REC[k];
            mcu.drive(1'b1, 4);
            run_fault(k, 4);
            cmp <= 6'h30;
            mcu.drive(1'b1, 8);
            check(fault_cnt, 8'h00, "early fault");
            fault_ready <= (k != 2);
            run_fault(k, 5);
            cmp <= 6'h30;
            mcu.drive(1'b1, 6);
            if (k == 2) check(fault_cnt, 8'h00, "stalled");
            fault_ready <= 1'b1;
            mcu.drive(1'b1, 6);
            check(fault_cnt != 0, 8'h01, "fault seen");
            check(last_fault, 8'h20 >> k, "fault word");
        end
        check(overrun, 8'h00, "overrun");
        chip_normal <= 1'b0;
        cfg(2'h0, 2'h0, 1'b1, 1'b1);
        check({wake_rx_en, bias_gnd, split_en, drv_en}, 8'h0C, "sleep");
        irq_cnt = 0;
        chip_cnt = 0;
        pulse(100);
        check(wake_flag, 8'h00, "short pulse");
        pulse(210);
        check({wake_flag, irq_cnt[1:0], chip_cnt[1:0]}, 8'h15, "wake");
        clear_wake;
        cfg(2'h0, 2'h0, 1'b1, 1'b0);
        repeat (3) pulse(30);
        check(wake_flag, 8'h00, "narrow");
        repeat (2) pulse(60);
        step(WWIN + 50);
        check(wake_flag, 8'h00, "window");
        repeat (3) pulse(60);
        check(wake_flag, 8'h01, "pattern");
        clear_wake;
        cfg(2'h0, 2'h0, 1'b0, 1'b1);
        pulse(210);
        check({wake_rx_en, wake_flag}, 8'h00, "disabled");
        chip_normal <= 1'b1;
        cfg(2'h2, 2'h0, 1'b0, 1'b0);
        check({bias_gnd, split_en, drv_en}, 8'h03, "back");
        give_verdict;
    end
endmodule : tb_can_transceiver_control
